// ==== dia_cfg.svh ====
// Addresses, field positions, fixed values and reset values of the info area
`ifndef DIA_CFG_SVH
`define DIA_CFG_SVH

// ****************************************************************
// Identification words
// ****************************************************************
`define DIA_ADDR_REV       16'h8005
`define DIA_ADDR_PART      16'h8006
`define DIA_REV_PFX_HI     13
`define DIA_REV_PFX_LO     12
`define DIA_REV_PFX_VAL    2'h2
`define DIA_MJR_HI         11
`define DIA_MJR_LO         6
`define DIA_MNR_HI         5
`define DIA_MNR_LO         0

// ****************************************************************
// Factory information area
// ****************************************************************
`define DIA_AREA_BASE      16'h8100
`define DIA_AREA_LAST      16'h811F
`define DIA_SER_FIRST      5'h00
`define DIA_SER_LAST       5'h08
`define DIA_SER_RSVD       5'h09
`define DIA_CUST_FIRST     5'h0A
`define DIA_CUST_LAST      5'h11
`define DIA_TLR_UNUSED_A   5'h12
`define DIA_TEMP_LOW       5'h13
`define DIA_TLR_UNUSED_B   5'h14
`define DIA_THR_UNUSED_A   5'h15
`define DIA_TEMP_HIGH      5'h16
`define DIA_THR_UNUSED_B   5'h17
`define DIA_ADC_G1         5'h18
`define DIA_ADC_G2         5'h19
`define DIA_ADC_G4         5'h1A
`define DIA_CMP_G1         5'h1B
`define DIA_CMP_G2         5'h1C
`define DIA_CMP_G4         5'h1D
`define DIA_TAIL_A         5'h1E
`define DIA_TAIL_B         5'h1F

// ****************************************************************
// Values
// ****************************************************************
`define DIA_BLANK          14'h3FFF
`define DIA_ADC_BITS       10
`define DIA_ADC_MASK       14'h03FF
`define DIA_WORD_RST       14'h3FFF
`define DIA_DATA_RST       14'h0000

`endif

// ==== dia_pkg.sv ====
// Types shared by the info area modules
package dia_pkg;

	typedef logic [13:0] dia_word_t;
	typedef logic [15:0] dia_addr_t;
	typedef logic [4:0]  dia_idx_t;

	typedef enum logic [2:0] {
		DIA_ST_IDLE = 3'h1,
		DIA_ST_CPU  = 3'h2,
		DIA_ST_TOOL = 3'h4
	} dia_state_e;

endpackage

// ==== dia_sync2.sv ====
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module dia_sync2 #(
	parameter int W = 1
) (
	input  wire logic         i_clk,
	input  wire logic         i_rst,
	input  wire logic [W-1:0] i_async,
	output logic      [W-1:0] o_sync
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] sync;
	} dia_sync_s;

	dia_sync_s st_ff;
	dia_sync_s nxt_st;

	always_comb begin
		nxt_st      = st_ff;
		nxt_st.meta = i_async;
		nxt_st.sync = st_ff.meta;
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign o_sync = st_ff.sync;
endmodule

// ==== dia_word_store.sv ====
// Thirty-two word flip-flop store of the factory information area
`timescale 1ns/1ps
`include "dia_cfg.svh"
module dia_word_store (
	input  wire logic               i_clk,
	input  wire logic               i_rst,
	input  wire logic               i_wr,
	input  wire dia_pkg::dia_idx_t  i_wr_idx,
	input  wire dia_pkg::dia_word_t i_wr_data,
	input  wire dia_pkg::dia_idx_t  i_rd_idx,
	output dia_pkg::dia_word_t      o_rd_data
);
	import dia_pkg::*;

	typedef struct packed {
		logic [31:0][13:0] mem;
	} dia_store_s;

	dia_store_s  st_ff;
	dia_store_s  nxt_st;
	logic [31:0] wr_hit;

	genvar g;
	generate
		for (g = 0; g < 32; g++) begin : g_dec
			assign wr_hit[g] = i_wr && (i_wr_idx == 5'(g));
		end
	endgenerate

	always_comb begin
		nxt_st = st_ff;
		for (int k = 0; k < 32; k++) begin
			if (wr_hit[k]) begin
				nxt_st.mem[k] = i_wr_data;
			end
		end
	end

	// Erased state until the manufacturing pass programs the words
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			st_ff <= {32{`DIA_WORD_RST}};
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign o_rd_data = st_ff.mem[i_rd_idx];
endmodule

// ==== dia_info_area.sv ====
// Read-only identification words and factory information area
`timescale 1ns/1ps
`include "dia_cfg.svh"

// Overview of operation
// - Part code word reads at 8006h, code in bits 13..0.
// - Revision word reads at 8005h, just below the part code.
// - Writes or erases aimed at identification words change nothing.
// - Software reads all words through the memory control read port.
// - Revision bits 13..12 always read binary 10.
// - Revision major field in bits 11..6, minor in bits 5..0.
// - Info area 8100h..811Fh written only in manufacture, then read-only.
// - Nine serial words at 8100h..8108h; 8109h reserved.
// - Bulk or user erase leaves the nine serial words intact.
// - Customer words 810Ah..8111h survive bulk erase unchanged.
// - Sensor readings at 8113h low, 8116h high range; rest unassigned.
// - Temperature readings are stored right-justified.
// - 8118h..811Dh: ADC then comparator reference mV, 1x 2x 4x.
// - Low-voltage variant 4x reference words hold no value.
module dia_info_area #(
	parameter logic [13:0] PART_CODE = 14'h1234, // Arbitrary value
	parameter logic [5:0]  MAJOR_REV = 6'h01,    // Arbitrary value
	parameter logic [5:0]  MINOR_REV = 6'h00,    // Arbitrary value
	parameter bit          LOW_VOLT  = 1'b0
) (
	input  wire logic               i_clk,
	input  wire logic               i_rst,
	input  wire logic               i_nvm_rd,
	input  wire logic               i_nvm_wr,
	input  wire logic               i_nvm_erase,
	input  wire logic               i_bulk_erase,
	input  wire dia_pkg::dia_addr_t i_nvm_addr,
	input  wire logic               i_tool_rd,
	input  wire dia_pkg::dia_addr_t i_tool_addr,
	input  wire logic               i_mfg_mode,
	input  wire logic               i_mfg_wr,
	input  wire dia_pkg::dia_idx_t  i_mfg_idx,
	input  wire dia_pkg::dia_word_t i_mfg_data,
	output dia_pkg::dia_word_t      o_nvm_data,
	output logic                    o_nvm_valid,
	output logic                    o_nvm_hit,
	output logic                    o_nvm_refused,
	output dia_pkg::dia_word_t      o_tool_data,
	output logic                    o_tool_valid
);
	import dia_pkg::*;

	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		dia_state_e state;
		dia_word_t  nvm_data;
		logic       nvm_valid;
		logic       nvm_hit;
		logic       nvm_refused;
		dia_word_t  tool_data;
		logic       tool_valid;
		logic       tool_rd_d;
		logic       tool_pend;
		dia_addr_t  tool_addr;
	} dia_state_s;

	dia_state_s st_ff;
	dia_state_s nxt_st;

	logic      tool_rd_s;
	dia_addr_t tool_addr_s;
	logic      mfg_mode_s;
	logic      store_wr;
	dia_word_t store_wdata;
	dia_idx_t  rd_idx;
	dia_word_t store_rdata;
	dia_addr_t sel_addr;
	dia_word_t sel_word;
	logic      sel_hit;

	// ****************************************************************
	// Pin inputs from the programmer
	// ****************************************************************
	dia_sync2 #(.W(1)) u_sync_rd (
		.i_clk   (i_clk),
		.i_rst   (i_rst),
		.i_async (i_tool_rd),
		.o_sync  (tool_rd_s)
	);

	// Programmer holds the address steady around its strobe
	dia_sync2 #(.W(16)) u_sync_addr (
		.i_clk   (i_clk),
		.i_rst   (i_rst),
		.i_async (i_tool_addr),
		.o_sync  (tool_addr_s)
	);

	dia_sync2 #(.W(1)) u_sync_mfg (
		.i_clk   (i_clk),
		.i_rst   (i_rst),
		.i_async (i_mfg_mode),
		.o_sync  (mfg_mode_s)
	);

	// ****************************************************************
	// Factory store
	// ****************************************************************
	// Only the manufacturing pass reaches the store; no user path writes
	assign store_wr = mfg_mode_s && i_mfg_wr;

	// Sensor readings keep only the low ADC bits
	always_comb begin
		store_wdata = i_mfg_data;
		if (i_mfg_idx == `DIA_TEMP_LOW || i_mfg_idx == `DIA_TEMP_HIGH) begin
			store_wdata = i_mfg_data & `DIA_ADC_MASK;
		end
	end

	assign rd_idx = sel_addr[4:0];

	dia_word_store u_store (
		.i_clk     (i_clk),
		.i_rst     (i_rst),
		.i_wr      (store_wr),
		.i_wr_idx  (i_mfg_idx),
		.i_wr_data (store_wdata),
		.i_rd_idx  (rd_idx),
		.o_rd_data (store_rdata)
	);

	// ****************************************************************
	// Read decode, shared by both readers
	// ****************************************************************
	// Software wins a same-cycle clash; the programmer waits one cycle
	assign sel_addr = i_nvm_rd ? i_nvm_addr : st_ff.tool_addr;

	always_comb begin
		sel_word = `DIA_BLANK;
		sel_hit  = 1'b1;
		if (sel_addr == `DIA_ADDR_PART) begin
			sel_word = PART_CODE;
		end else if (sel_addr == `DIA_ADDR_REV) begin
			sel_word = {`DIA_REV_PFX_VAL, MAJOR_REV, MINOR_REV};
		end else if (sel_addr >= `DIA_AREA_BASE &&
				sel_addr <= `DIA_AREA_LAST) begin
			unique case (rd_idx)
				`DIA_SER_RSVD,
				`DIA_TLR_UNUSED_A, `DIA_TLR_UNUSED_B,
				`DIA_THR_UNUSED_A, `DIA_THR_UNUSED_B,
				`DIA_TAIL_A, `DIA_TAIL_B: begin
					sel_word = `DIA_BLANK;
				end
				`DIA_ADC_G4, `DIA_CMP_G4: begin
					sel_word = LOW_VOLT ? `DIA_BLANK : store_rdata;
				end
				default: begin
					sel_word = store_rdata;
				end
			endcase
		end else begin
			sel_hit = 1'b0;
		end
	end

	// ****************************************************************
	// Answer sequencing
	// ****************************************************************
	always_comb begin
		nxt_st             = st_ff;
		nxt_st.nvm_valid   = 1'b0;
		nxt_st.nvm_refused = 1'b0;
		nxt_st.tool_valid  = 1'b0;
		nxt_st.tool_rd_d   = tool_rd_s;
		nxt_st.state       = DIA_ST_IDLE;
		// Contents are fixed; the attempt is only flagged
		if (i_nvm_wr || i_nvm_erase || i_bulk_erase) begin
			nxt_st.nvm_refused = 1'b1;
		end
		if (i_nvm_rd) begin
			nxt_st.state     = DIA_ST_CPU;
			nxt_st.nvm_valid = 1'b1;
			nxt_st.nvm_data  = sel_word;
			nxt_st.nvm_hit   = sel_hit;
		end else if (st_ff.tool_pend) begin
			nxt_st.state      = DIA_ST_TOOL;
			nxt_st.tool_valid = 1'b1;
			nxt_st.tool_data  = sel_word;
			nxt_st.tool_pend  = 1'b0;
		end
		// After the service: a new pin edge in that cycle must not be lost
		if (tool_rd_s && !st_ff.tool_rd_d) begin
			nxt_st.tool_pend = 1'b1;
			nxt_st.tool_addr = tool_addr_s;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			st_ff.state       <= DIA_ST_IDLE;
			st_ff.nvm_data    <= `DIA_DATA_RST;
			st_ff.nvm_valid   <= 1'b0;
			st_ff.nvm_hit     <= 1'b0;
			st_ff.nvm_refused <= 1'b0;
			st_ff.tool_data   <= `DIA_DATA_RST;
			st_ff.tool_valid  <= 1'b0;
			st_ff.tool_rd_d   <= 1'b0;
			st_ff.tool_pend   <= 1'b0;
			st_ff.tool_addr   <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign o_nvm_data    = st_ff.nvm_data;
	assign o_nvm_valid   = st_ff.nvm_valid;
	assign o_nvm_hit     = st_ff.nvm_hit;
	assign o_nvm_refused = st_ff.nvm_refused;
	assign o_tool_data   = st_ff.tool_data;
	assign o_tool_valid  = st_ff.tool_valid;

	// ****************************************************************
	// Checks
	// ****************************************************************
	a_part_read: assert property (@(posedge i_clk) disable iff (i_rst)
		i_nvm_rd && i_nvm_addr == `DIA_ADDR_PART |=>
		o_nvm_valid && o_nvm_data == PART_CODE)
		else $error("part code word read wrong");

	a_rev_read: assert property (@(posedge i_clk) disable iff (i_rst)
		i_nvm_rd && i_nvm_addr == `DIA_ADDR_REV |=>
		o_nvm_data[`DIA_MJR_HI:`DIA_MNR_LO] == {MAJOR_REV, MINOR_REV})
		else $error("revision word fields wrong");

	a_rev_prefix: assert property (@(posedge i_clk) disable iff (i_rst)
		i_nvm_rd && i_nvm_addr == `DIA_ADDR_REV |=>
		o_nvm_data[`DIA_REV_PFX_HI:`DIA_REV_PFX_LO] == `DIA_REV_PFX_VAL)
		else $error("revision prefix not 10");

	a_erase_keeps: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_bulk_erase || i_nvm_erase) && !store_wr |=>
		$stable(u_store.st_ff.mem[8:0]))
		else $error("serial words changed by erase");

	a_cust_keeps: assert property (@(posedge i_clk) disable iff (i_rst)
		!store_wr |=> $stable(u_store.st_ff.mem[17:10]))
		else $error("customer words changed outside manufacture");

	a_refuse_flag: assert property (@(posedge i_clk) disable iff (i_rst)
		i_nvm_wr |=> o_nvm_refused ##1 !o_nvm_refused || $past(i_nvm_wr))
		else $error("write attempt not refused");

	a_blank_rsvd: assert property (@(posedge i_clk) disable iff (i_rst)
		i_nvm_rd && i_nvm_addr == 16'h8109 |=> o_nvm_data == `DIA_BLANK)
		else $error("reserved word not fixed value");

	a_lv_blank: assert property (@(posedge i_clk) disable iff (i_rst)
		LOW_VOLT && i_nvm_rd && i_nvm_addr == 16'h811D |=>
		o_nvm_data == `DIA_BLANK)
		else $error("low-voltage 4x word holds value");

	a_tool_answer: assert property (@(posedge i_clk) disable iff (i_rst)
		tool_rd_s && !st_ff.tool_rd_d |-> ##[1:3] o_tool_valid)
		else $error("programmer read not answered");

	a_temp_just: assert property (@(posedge i_clk) disable iff (i_rst)
		store_wr && i_mfg_idx == `DIA_TEMP_LOW |=>
		u_store.st_ff.mem[19][13:10] == 4'h0)
		else $error("temperature word not right-justified");

	a_valid_once: assert property (@(posedge i_clk) disable iff (i_rst)
		o_nvm_valid == $past(i_nvm_rd))
		else $error("read valid not one cycle after strobe");

	a_miss_blank: assert property (@(posedge i_clk) disable iff (i_rst)
		i_nvm_rd && i_nvm_addr != `DIA_ADDR_REV &&
		i_nvm_addr != `DIA_ADDR_PART && (i_nvm_addr < `DIA_AREA_BASE ||
		i_nvm_addr > `DIA_AREA_LAST) |=> !o_nvm_hit && o_nvm_data == `DIA_BLANK)
		else $error("unmapped read not blank");

	a_erase_ref: assert property (@(posedge i_clk) disable iff (i_rst)
		i_nvm_erase || i_bulk_erase |=> o_nvm_refused)
		else $error("erase attempt not refused");

	a_store_lock: assert property (@(posedge i_clk) disable iff (i_rst)
		!mfg_mode_s |=> $stable(u_store.st_ff))
		else $error("store changed outside manufacture");

	a_temp_high: assert property (@(posedge i_clk) disable iff (i_rst)
		store_wr && i_mfg_idx == `DIA_TEMP_HIGH |=>
		u_store.st_ff.mem[22][13:10] == 4'h0)
		else $error("high-range word not right-justified");

	a_area_hit: assert property (@(posedge i_clk) disable iff (i_rst)
		i_nvm_rd && i_nvm_addr >= `DIA_AREA_BASE &&
		i_nvm_addr <= `DIA_AREA_LAST |=> o_nvm_valid && o_nvm_hit)
		else $error("info area read not flagged as hit");

	a_lv_adc4: assert property (@(posedge i_clk) disable iff (i_rst)
		LOW_VOLT && i_nvm_rd && i_nvm_addr == 16'h811A |=>
		o_nvm_data == `DIA_BLANK)
		else $error("low-voltage 4x ADC word holds value");

	a_tool_part: assert property (@(posedge i_clk) disable iff (i_rst)
		st_ff.tool_pend && !i_nvm_rd && st_ff.tool_addr == `DIA_ADDR_PART |=>
		st_ff.state == DIA_ST_TOOL && o_tool_valid &&
		o_tool_data == PART_CODE)
		else $error("programmer part code read wrong");

	a_sw_first: assert property (@(posedge i_clk) disable iff (i_rst)
		i_nvm_rd && st_ff.tool_pend |=>
		st_ff.state == DIA_ST_CPU && o_nvm_valid && !o_tool_valid)
		else $error("software read lost priority");
endmodule

// ==== dia_tool_model.sv ====
// Programmer model driving the read request and address pins
`timescale 1ns/1ps
module dia_tool_model (
	input  wire logic               i_clk,
	input  wire logic               i_go,
	input  wire dia_pkg::dia_addr_t i_addr,
	input  wire logic               i_tool_valid,
	input  wire dia_pkg::dia_word_t i_tool_data,
	output logic                    o_tool_rd,
	output dia_pkg::dia_addr_t      o_tool_addr,
	output dia_pkg::dia_word_t      o_data,
	output logic                    o_done,
	output logic                    o_late
);
	import dia_pkg::*;
	int n;
	initial begin
		o_tool_rd   = 1'b0;
		o_tool_addr = 16'h0000;
		o_data      = 14'h0000;
		o_done      = 1'b0;
		o_late      = 1'b0;
	end
	always begin
		@(posedge i_clk);
		if (i_go === 1'b1) begin
			// Address settles three cycles before the request edge
			o_tool_addr <= i_addr;
			repeat (3) @(posedge i_clk);
			o_tool_rd <= 1'b1;
			n = 0;
			do begin
				@(posedge i_clk);
				n++;
			end while (i_tool_valid !== 1'b1 && n < 20);
			o_late      <= (i_tool_valid !== 1'b1);
			o_data      <= i_tool_data;
			o_tool_rd   <= 1'b0;
			// Released pins must not keep showing the old address
			o_tool_addr <= ~o_tool_addr;
			repeat (3) @(posedge i_clk);
			o_done <= 1'b1;
			@(posedge i_clk);
			o_done <= 1'b0;
		end
	end
endmodule

// ==== dia_info_area_tb.sv ====
// Self-checking bench for the info area with a programmer model
`timescale 1ns/1ps
module dia_info_area_tb;
	import dia_pkg::*;
	localparam logic [13:0] P_PART = 14'h2A5C; // Arbitrary value
	localparam logic [5:0]  P_MJR  = 6'h15;    // Arbitrary value
	localparam logic [5:0]  P_MNR  = 6'h2A;    // Arbitrary value
	logic      clk, rst, rd, wr, er, bulk, mode, mwr, go;
	logic      tool_rd, valid, hit, refused, tool_valid, done, late;
	dia_addr_t addr, tool_addr, go_addr;
	dia_idx_t  midx;
	dia_word_t mdata, data, tool_data, got_tool, lv_data;
	int        error_cnt, compares;

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	dia_info_area #(.PART_CODE(P_PART), .MAJOR_REV(P_MJR),
		.MINOR_REV(P_MNR), .LOW_VOLT(1'b0)) u_dut (
		.i_clk(clk), .i_rst(rst), .i_nvm_rd(rd), .i_nvm_wr(wr),
		.i_nvm_erase(er), .i_bulk_erase(bulk), .i_nvm_addr(addr),
		.i_tool_rd(tool_rd), .i_tool_addr(tool_addr), .i_mfg_mode(mode),
		.i_mfg_wr(mwr), .i_mfg_idx(midx), .i_mfg_data(mdata),
		.o_nvm_data(data), .o_nvm_valid(valid), .o_nvm_hit(hit),
		.o_nvm_refused(refused), .o_tool_data(tool_data),
		.o_tool_valid(tool_valid));
	// Low-voltage variant shares every input with the main instance
	dia_info_area #(.LOW_VOLT(1'b1)) u_dut_lv (
		.i_clk(clk), .i_rst(rst), .i_nvm_rd(rd), .i_nvm_wr(wr),
		.i_nvm_erase(er), .i_bulk_erase(bulk), .i_nvm_addr(addr),
		.i_tool_rd(tool_rd), .i_tool_addr(tool_addr), .i_mfg_mode(mode),
		.i_mfg_wr(mwr), .i_mfg_idx(midx), .i_mfg_data(mdata),
		.o_nvm_data(lv_data), .o_nvm_valid(), .o_nvm_hit(),
		.o_nvm_refused(), .o_tool_data(), .o_tool_valid());
	dia_tool_model u_tool (
		.i_clk(clk), .i_go(go), .i_addr(go_addr),
		.i_tool_valid(tool_valid), .i_tool_data(tool_data),
		.o_tool_rd(tool_rd), .o_tool_addr(tool_addr), .o_data(got_tool),
		.o_done(done), .o_late(late));

	// ****************************************************************
	// Compare and access tasks
	// ****************************************************************
	task automatic chk_w(input string what, input dia_word_t exp,
		input dia_word_t got);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic chk_b(input string what, input logic exp, input logic got);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch %s expected %b seen %b", what, exp, got);
		end
	endtask
	task automatic rd_chk(input dia_addr_t a, input dia_word_t exp,
		input logic exp_hit);
		@(posedge clk);
		rd   <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk_b("read valid", 1'b1, valid);
		chk_w("read data", exp, data);
		chk_b("read hit", exp_hit, hit);
	endtask
	task automatic tool_chk(input dia_addr_t a, input dia_word_t exp);
		int n;
		@(posedge clk);
		go      <= 1'b1;
		go_addr <= a;
		@(posedge clk);
		go <= 1'b0;
		n = 0;
		while (done !== 1'b1 && n < 40) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk_b("tool late", 1'b0, late);
		chk_w("tool data", exp, got_tool);
	endtask
	// Pattern written at factory, as each word should read back
	function automatic dia_word_t exp_w(input dia_idx_t i, input logic lv);
		dia_word_t d;
		d = {i, 9'h155};
		case (i)
			5'h09, 5'h12, 5'h14, 5'h15, 5'h17, 5'h1E, 5'h1F: exp_w = 14'h3FFF;
			5'h13, 5'h16: exp_w = d & 14'h03FF;
			5'h1A, 5'h1D: exp_w = lv ? 14'h3FFF : d;
			default: exp_w = d;
		endcase
	endfunction

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic t_ident;
		rd_chk(16'h8006, P_PART, 1'b1);
		rd_chk(16'h8005, {2'h2, P_MJR, P_MNR}, 1'b1);
		$display("test ident done");
	endtask
	task automatic t_blank;
		rd_chk(16'h8100, 14'h3FFF, 1'b1);
		rd_chk(16'h8007, 14'h3FFF, 1'b0);
		rd_chk(16'h80FF, 14'h3FFF, 1'b0);
		rd_chk(16'h8120, 14'h3FFF, 1'b0);
		$display("test blank done");
	endtask
	task automatic t_mfg;
		@(posedge clk);
		mode <= 1'b1;
		repeat (4) @(posedge clk);
		// Strobe held high: back-to-back factory writes
		for (int i = 0; i < 32; i++) begin
			mwr   <= 1'b1;
			midx  <= 5'(i);
			mdata <= {5'(i), 9'h155};
			@(posedge clk);
		end
		mwr  <= 1'b0;
		mode <= 1'b0;
		for (int i = 0; i < 32; i++) begin
			rd_chk(16'h8100 + 16'(i), exp_w(5'(i), 1'b0), 1'b1);
			chk_w("low volt word", exp_w(5'(i), 1'b1), lv_data);
		end
		rd_chk(16'h8113, exp_w(5'h13, 1'b0), 1'b1);
		rd_chk(16'h8119, exp_w(5'h19, 1'b0), 1'b1);
		rd_chk(16'h8109, 14'h3FFF, 1'b1);
		repeat (4) @(posedge clk);
		mwr   <= 1'b1;
		midx  <= 5'h00;
		mdata <= 14'h0000;
		@(posedge clk);
		mwr <= 1'b0;
		rd_chk(16'h8100, exp_w(5'h00, 1'b0), 1'b1);
		$display("test factory done");
	endtask
	task automatic t_refuse;
		dia_addr_t al [3];
		al = '{16'h8005, 16'h8006, 16'h8100};
		for (int k = 0; k < 3; k++) begin
			for (int j = 0; j < 3; j++) begin
				@(posedge clk);
				wr   <= (k == 0);
				er   <= (k == 1);
				bulk <= (k == 2);
				addr <= al[j];
				@(posedge clk);
				{wr, er, bulk} <= 3'h0;
				#1;
				chk_b("refused", 1'b1, refused);
			end
		end
		rd_chk(16'h8006, P_PART, 1'b1);
		rd_chk(16'h8005, {2'h2, P_MJR, P_MNR}, 1'b1);
		for (int i = 0; i < 18; i++)
			rd_chk(16'h8100 + 16'(i), exp_w(5'(i), 1'b0), 1'b1);
		$display("test refuse done");
	endtask
	task automatic t_tool;
		tool_chk(16'h8006, P_PART);
		tool_chk(16'h8005, {2'h2, P_MJR, P_MNR});
		tool_chk(16'h8116, exp_w(5'h16, 1'b0));
		$display("test tool done");
	endtask
	task automatic t_clash;
		fork
			tool_chk(16'h8113, exp_w(5'h13, 1'b0));
			begin
				// Software read lands in the cycle the pin read is pending
				repeat (8) @(posedge clk);
				rd   <= 1'b1;
				addr <= 16'h8005;
				@(posedge clk);
				rd <= 1'b0;
				#1;
				chk_w("clash data", {2'h2, P_MJR, P_MNR}, data);
				chk_b("tool waits", 1'b0, tool_valid);
				@(posedge clk);
				#1;
				chk_b("tool served", 1'b1, tool_valid);
			end
		join
		$display("test clash done");
	endtask

	task automatic test_done;
		$display("counts: %0d compares, %0d mismatches", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	initial begin
		{rst, rd, wr, er, bulk, mode, mwr, go} = 8'h80;
		addr      = 16'h0000;
		go_addr   = 16'h0000;
		midx      = 5'h00;
		mdata     = 14'h0000;
		error_cnt = 0;
		compares  = 0;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		t_ident;
		t_blank;
		t_mfg;
		t_refuse;
		t_tool;
		t_clash;
		test_done;
	end
	// Whole run needs well under a thousand cycles
	initial begin
		#40000;
		error_cnt++;
		$display("watchdog expired");
		test_done;
	end
endmodule
